//--- serial_port_defs.svh
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// ----------------------------------------
// register addresses, channel zero
// ----------------------------------------
`define MODE_CTRL_CH0_ADDR   16'hff80
`define CLOCK_SEL_CH0_ADDR   16'hff81
`define TX_BUFFER_CH0_ADDR   16'hff82
`define SHIFT_REG_CH0_ADDR   16'hff83
// ----------------------------------------
// register addresses, channel one
// ----------------------------------------
`define MODE_CTRL_CH1_ADDR   16'hff88
`define CLOCK_SEL_CH1_ADDR   16'hff89
`define TX_BUFFER_CH1_ADDR   16'hff8a
`define SHIFT_REG_CH1_ADDR   16'hff8b

// ----------------------------------------
// mode control field positions
// ----------------------------------------
`define MODE_ENABLE_BIT      7
`define MODE_TXRX_BIT        6
`define MODE_SS_USE_BIT      5
`define MODE_ORDER_BIT       4
`define MODE_BUSY_BIT        0
// ----------------------------------------
// clock select field positions
// ----------------------------------------
`define CSEL_POL_BIT         4
`define CSEL_PHASE_BIT       3
`define CSEL_DIV_MSB         2

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define MODE_RESET           8'h00
`define CSEL_RESET           8'h00
`define SHIFT_RESET          8'h00
`define DIV_SLAVE_CODE       3'h7
`define EDGES_PER_BYTE       5'h10

`endif

//--- serial_port_pkg.sv
package serial_port_pkg;

   // ----------------------------------------
   // register images
   // ----------------------------------------
   typedef struct packed {
      logic enable;     // channel_enable
      logic txrx;       // txrx_mode_bit
      logic ss_use;     // slave_select_use, channel one only
      logic lsb_first;  // bit_order_sel
   } mode_t;

   typedef struct packed {
      logic       pol;  // clock_polarity_sel
      logic       pha;  // data_phase_sel
      logic [2:0] div;  // clock_divider_sel
   } clk_sel_t;

   // ----------------------------------------
   // transfer sequencer
   // ----------------------------------------
   typedef enum logic {
      XFER_IDLE,
      XFER_RUN
   } xfer_state_t;

endpackage

//--- serial_clock_divider.sv
`timescale 1ns/1ns
`include "serial_port_defs.svh"

module serial_clock_divider (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,   // counts only while a master transfer runs
   input  wire logic [2:0] code,  // clock_divider_sel
   output logic            tick   // one pulse per serial clock half period
);
   import serial_port_pkg::*;

   logic [6:0] count;  // half period counter

   // ----------------------------------------
   // terminal count, half period length in system clocks minus one
   // ----------------------------------------
   function automatic logic [6:0] half_len(input logic [2:0] c);
      // fx/2 gives one cycle per half, each code step doubles it
      half_len = 7'(7'h01 << c) - 7'h01;
   endfunction

   // terminal count reached
   assign tick = run && (count == half_len(code));

   // ----------------------------------------
   // counter, restarted whenever no transfer runs
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 7'h00;
      end else if (!run || tick) begin
         // restart keeps the first half period full length
         count <= 7'h00;
      end else begin
         count <= count + 7'h01;
      end
   end

endmodule

//--- three_wire_clocked_serial_port.sv
`timescale 1ns/1ns
`include "serial_port_defs.svh"
// Functional notes
// - eight bit shift register per channel
// - shift register read starts reception, receive mode
// - reception samples serial input into shift register
// - reset clears shift, mode, clock registers
// - enable low clears busy and shift register
// - mode bit: receive only or transmit/receive
// - receive only holds serial output low
// - bit order msb or lsb first
// - mode bit zero is read-only busy
// - channel one slave select use bit
// - polarity and phase pick four timing types
// - divider code picks master rate or slave
// - bit and byte writes to control registers
// - buffer write starts transmit/receive transfer

module three_wire_clocked_serial_port (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // ----------------------------------------
   // processor side
   // ----------------------------------------
   input  wire logic [15:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic [7:0]  bus_wmask,       // all ones for byte writes
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic      [7:0]  bus_rdata,
   output logic             bus_rvalid,
   // ----------------------------------------
   // serial pins, index is channel
   // ----------------------------------------
   input  wire logic [1:0]  serial_clock_line_in,
   output logic      [1:0]  serial_clock_line_out,
   output logic      [1:0]  serial_clock_line_oe_n,
   input  wire logic [1:0]  serial_in_line,
   output logic      [1:0]  serial_out_line,
   output logic      [1:0]  serial_out_line_oe_n,
   input  wire logic        slave_select_in_n   // channel one only
);
   import serial_port_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // merge a masked write, single bit and byte writes alike
   function automatic logic [7:0] merge(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic [7:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   // bit that leaves the shift register next
   function automatic logic out_end(input logic [7:0] v, input logic lsb);
      out_end = lsb ? v[0] : v[7];
   endfunction

   localparam logic [15:0] MODE_ADDR [2] = '{`MODE_CTRL_CH0_ADDR, `MODE_CTRL_CH1_ADDR};
   localparam logic [15:0] CSEL_ADDR [2] = '{`CLOCK_SEL_CH0_ADDR, `CLOCK_SEL_CH1_ADDR};
   localparam logic [15:0] TXB_ADDR  [2] = '{`TX_BUFFER_CH0_ADDR, `TX_BUFFER_CH1_ADDR};
   localparam logic [15:0] SHR_ADDR  [2] = '{`SHIFT_REG_CH0_ADDR, `SHIFT_REG_CH1_ADDR};

   mode_t       mode      [2];  // serial_mode_ctrl images
   clk_sel_t    csel      [2];  // serial_clock_sel images
   logic [7:0]  tx_buf    [2];  // transmit_buffer
   logic [7:0]  shift_reg [2];  // shift_register
   xfer_state_t state     [2];  // busy_flag is state == XFER_RUN
   logic [7:0]  rd_mux    [2];  // per channel read data, zero when unmapped

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic       hit_mode;      // mode register addressed
         logic       hit_csel;      // clock select addressed
         logic       hit_txb;       // transmit buffer addressed
         logic       hit_shr;       // shift register addressed
         logic [7:0] mode_img;      // mode register as read
         logic [7:0] next_mode;     // mode register after a write
         logic       busy;          // transfer in progress
         logic       start_tx;      // buffer write launches a transfer
         logic       start_rx;      // shift register read launches one
         logic       master;        // internal divider drives the clock
         logic       selected;      // slave select lets edges through
         logic       tick;          // divider half period
         logic       phase;         // master clock, relative to idle
         logic       sck_q;         // sampled external clock
         logic       lead;          // leading serial clock edge
         logic       trail;         // trailing serial clock edge
         logic       sample_edge;   // edge that captures the input
         logic       launch_edge;   // edge that updates the output
         logic [4:0] edge_cnt;      // edges seen in this byte
         logic       out_bit;       // output data latch

         assign hit_mode = (bus_addr == MODE_ADDR[ch]);
         assign hit_csel = (bus_addr == CSEL_ADDR[ch]);
         assign hit_txb  = (bus_addr == TXB_ADDR[ch]);
         assign hit_shr  = (bus_addr == SHR_ADDR[ch]);
         assign busy     = (state[ch] == XFER_RUN);

         // busy is bit zero and cannot be written
         assign mode_img = {mode[ch].enable, mode[ch].txrx, mode[ch].ss_use,
                            mode[ch].lsb_first, 3'h0, busy};
         assign next_mode = merge(mode_img, bus_wdata, bus_wmask);

         assign start_tx = bus_wr && hit_txb && mode[ch].enable
                           && mode[ch].txrx && !busy;
         assign start_rx = bus_rd && hit_shr && mode[ch].enable
                           && !mode[ch].txrx && !busy;

         // ----------------------------------------
         // serial clock source
         // ----------------------------------------
         assign master = (csel[ch].div != `DIV_SLAVE_CODE);
         // deselected slave ignores the clock, channel zero always selected
         assign selected = !((ch == 1) && mode[ch].ss_use
                             && slave_select_in_n);

         serial_clock_divider u_div (
            .clk   (clk),
            .rst_n (rst_n),
            .run   (busy && master),
            .code  (csel[ch].div),
            .tick  (tick)
         );

         // external clock is taken as synchronous, one stage of history
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sck_q <= 1'b0;
            end else begin
               sck_q <= serial_clock_line_in[ch];
            end
         end

         // edges measured against the idle level set by polarity
         always_comb begin
            if (master) begin
               lead  = tick && !phase;
               trail = tick && phase;
            end else begin
               lead  = selected && busy && (sck_q == csel[ch].pol)
                       && (serial_clock_line_in[ch] != csel[ch].pol);
               trail = selected && busy && (sck_q != csel[ch].pol)
                       && (serial_clock_line_in[ch] == csel[ch].pol);
            end
         end

         // phase zero captures on leading, phase one a half clock later
         assign sample_edge = csel[ch].pha ? trail : lead;
         assign launch_edge = csel[ch].pha ? lead : trail;

         // ----------------------------------------
         // mode and clock select registers
         // ----------------------------------------
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mode[ch] <= mode_t'(`MODE_RESET);
               csel[ch] <= clk_sel_t'(`CSEL_RESET);
            end else if (bus_wr) begin
               if (hit_mode) begin
                  mode[ch].enable    <= next_mode[`MODE_ENABLE_BIT];
                  mode[ch].txrx      <= next_mode[`MODE_TXRX_BIT];
                  // bit five has no storage on channel zero
                  mode[ch].ss_use    <= (ch == 1) && next_mode[`MODE_SS_USE_BIT];
                  mode[ch].lsb_first <= next_mode[`MODE_ORDER_BIT];
               end
               if (hit_csel) begin
                  // software keeps this stable while enabled
                  csel[ch] <= clk_sel_t'(merge({3'h0, csel[ch]}, bus_wdata,
                                               bus_wmask));
               end
            end
         end

         // ----------------------------------------
         // transmit buffer, plain storage
         // ----------------------------------------
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               tx_buf[ch] <= `SHIFT_RESET;
            end else if (bus_wr && hit_txb) begin
               tx_buf[ch] <= bus_wdata;
            end
         end

         // ----------------------------------------
         // sequencer: busy flag and edge count
         // ----------------------------------------
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               state[ch] <= XFER_IDLE;
               edge_cnt  <= 5'h00;
               phase     <= 1'b0;
            end else if (!mode[ch].enable) begin
               // disabling aborts whatever was in flight
               state[ch] <= XFER_IDLE;
               edge_cnt  <= 5'h00;
               phase     <= 1'b0;
            end else begin
               case (state[ch])
                  XFER_IDLE: begin
                     edge_cnt <= 5'h00;
                     phase    <= 1'b0;
                     if (start_tx || start_rx) begin
                        state[ch] <= XFER_RUN;
                     end
                  end
                  XFER_RUN: begin
                     if (lead || trail) begin
                        edge_cnt <= edge_cnt + 5'h01;
                        phase    <= !phase;
                        // sixteenth edge ends the eighth clock
                        if (edge_cnt == `EDGES_PER_BYTE - 5'h01) begin
                           state[ch] <= XFER_IDLE;
                        end
                     end
                  end
                  default: begin
                     state[ch] <= XFER_IDLE;
                  end
               endcase
            end
         end

         // ----------------------------------------
         // shift register and output latch
         // ----------------------------------------
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               shift_reg[ch] <= `SHIFT_RESET;
               out_bit       <= 1'b0;
            end else if (!mode[ch].enable) begin
               shift_reg[ch] <= `SHIFT_RESET;
               out_bit       <= 1'b0;
            end else if (start_tx) begin
               // first bit is on the line before the first edge
               shift_reg[ch] <= bus_wdata;
               out_bit       <= out_end(bus_wdata, mode[ch].lsb_first);
            end else if (busy && sample_edge) begin
               if (mode[ch].lsb_first) begin
                  shift_reg[ch] <= {serial_in_line[ch], shift_reg[ch][7:1]};
               end else begin
                  shift_reg[ch] <= {shift_reg[ch][6:0], serial_in_line[ch]};
               end
            end else if (busy && launch_edge) begin
               out_bit <= out_end(shift_reg[ch], mode[ch].lsb_first);
            end
         end

         // ----------------------------------------
         // pins
         // ----------------------------------------
         // idle at polarity level, inverted during the active half
         assign serial_clock_line_out[ch]  = csel[ch].pol ^ phase;
         assign serial_clock_line_oe_n[ch] = !(mode[ch].enable && master);
         // receive only forces the line low rather than floating
         assign serial_out_line[ch] = mode[ch].txrx && out_bit;
         assign serial_out_line_oe_n[ch] = !(mode[ch].enable && selected);

         // ----------------------------------------
         // read mux
         // ----------------------------------------
         always_comb begin
            if (hit_mode) begin
               rd_mux[ch] = mode_img;
            end else if (hit_csel) begin
               rd_mux[ch] = {3'h0, csel[ch]};
            end else if (hit_txb) begin
               rd_mux[ch] = tx_buf[ch];
            end else if (hit_shr) begin
               rd_mux[ch] = shift_reg[ch];
            end else begin
               rd_mux[ch] = 8'h00;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // registered read answer, one cycle after the strobe
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_rdata  <= 8'h00;
         bus_rvalid <= 1'b0;
      end else begin
         bus_rvalid <= bus_rd;
         if (bus_rd) begin
            bus_rdata <= rd_mux[0] | rd_mux[1];
         end
      end
   end

endmodule

//--- serial_port_checker.sv
`timescale 1ns/1ns
module serial_port_checker (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0]  bus_wdata,
   input wire logic [7:0]  bus_wmask,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic        bus_rvalid,
   input wire logic [1:0]  serial_clock_line_out,
   input wire logic [1:0]  serial_clock_line_oe_n,
   input wire logic [1:0]  serial_out_line,
   input wire logic [1:0]  serial_out_line_oe_n
);
   // ----------------------------------------
   // channel zero shadow state
   // ----------------------------------------
   logic [7:0] mode0;     // mirrored mode control
   logic [7:0] csel0;     // mirrored clock select
   logic       run0;      // transfer believed in flight
   logic [4:0] edges0;    // serial clock edges seen
   logic       start0;    // accepted start request
   assign start0 = mode0[7] && ((bus_wr && bus_addr == 16'hff82 && mode0[6])
                || (bus_rd && bus_addr == 16'hff83 && !mode0[6]));
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // merged write, same as a masked bit write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode0 <= 8'h00;
      end else if (bus_wr && bus_addr == 16'hff80) begin
         mode0 <= (mode0 & ~bus_wmask) | (bus_wdata & bus_wmask);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         csel0 <= 8'h00;
      end else if (bus_wr && bus_addr == 16'hff81) begin
         csel0 <= (csel0 & ~bus_wmask) | (bus_wdata & bus_wmask);
      end
   end
   // edge counter; ends the frame after sixteen clock edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run0   <= 1'b0;
         edges0 <= 5'h00;
      end else if (!mode0[7] || edges0 == 5'h10) begin
         run0   <= 1'b0;
         edges0 <= 5'h00;
      end else if (!run0 && start0) begin
         run0 <= 1'b1;
      end else if (run0 && $changed(serial_clock_line_out[0])) begin
         edges0 <= edges0 + 5'h01;
      end
   end
   a_read_answer: assert property (bus_rd |=> bus_rvalid)
      else $error("read got no answer");
   a_answer_cause: assert property (bus_rvalid |-> $past(bus_rd))
      else $error("answer without read");
   a_rx_out_low: assert property (!mode0[6] |-> !serial_out_line[0])
      else $error("data out not low in receive mode");
   a_clk_drive: assert property (mode0[7] && csel0[2:0] != 3'h7 |->
      !serial_clock_line_oe_n[0])
      else $error("master clock not driven");
   a_clk_slave: assert property (csel0[2:0] == 3'h7 |-> serial_clock_line_oe_n[0])
      else $error("slave clock line driven");
   // fastest divider toggles every cycle, so the first change shows one cycle on
   a_first_edge: assert property ($rose(run0) && csel0[2:0] == 3'h0 |->
      serial_clock_line_out[0] == csel0[4] ##1 serial_clock_line_out[0] != csel0[4])
      else $error("first clock edge misplaced");
   // an enabled channel outside a frame keeps its clock still
   a_clock_stops: assert property (!run0 && mode0[7] |->
      $stable(serial_clock_line_out[0]))
      else $error("clock runs outside a frame");
   a_idle_level: assert property (!mode0[7] && !$past(mode0[7]) |->
      serial_clock_line_out[0] == csel0[4])
      else $error("idle clock level wrong");
   a_out_release: assert property (!mode0[7] |-> serial_out_line_oe_n[0])
      else $error("data out driven while disabled");
endmodule
bind three_wire_clocked_serial_port serial_port_checker serial_port_checker_inst (
   .clk, .rst_n, .bus_addr, .bus_wdata, .bus_wmask, .bus_wr, .bus_rd, .bus_rvalid,
   .serial_clock_line_out, .serial_clock_line_oe_n, .serial_out_line, .serial_out_line_oe_n);

//--- serial_peer_model.sv
`timescale 1ns/1ns
// type one peer: samples on rising clock, shifts on falling
module serial_peer_model (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       load,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte
);
   logic [7:0] tx_sh;   // outgoing bits, msb first
   assign miso = tx_sh[7];
   always @(posedge sck) begin
      rx_byte <= {rx_byte[6:0], mosi};
   end
   // vacated bit refills with inverted bit zero so stale data never looks valid
   always @(negedge sck or posedge load) begin
      if (load) begin
         tx_sh <= tx_byte;
      end else begin
         tx_sh <= {tx_sh[6:0], ~tx_sh[0]};
      end
   end
endmodule

//--- three_wire_clocked_serial_port_tb.sv
`timescale 1ns/1ns
module three_wire_clocked_serial_port_tb;
   logic        clk, rst_n, bus_wr, bus_rd, ss_n, load, bus_rvalid, sck0, mosi, miso;
   logic [15:0] addr;
   logic [7:0]  wdata, wmask, rdata, peer_tx, peer_rx, rv;
   logic [1:0]  sck_out, sck_oe_n, so, so_oe_n;
   int          err_count, tests_run, cycles;
   // pull-downs on released lines
   assign sck0 = sck_oe_n[0] ? 1'b0 : sck_out[0];
   assign mosi = so_oe_n[0] ? 1'b0 : so[0];
   three_wire_clocked_serial_port three_wire_clocked_serial_port_inst (
      .clk(clk), .rst_n(rst_n), .bus_addr(addr), .bus_wdata(wdata), .bus_wmask(wmask),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(rdata), .bus_rvalid(bus_rvalid),
      .serial_clock_line_in({1'b0, sck0}), .serial_clock_line_out(sck_out),
      .serial_clock_line_oe_n(sck_oe_n), .serial_in_line({1'b0, miso}),
      .serial_out_line(so), .serial_out_line_oe_n(so_oe_n), .slave_select_in_n(ss_n));
   serial_peer_model serial_peer_model_inst (
      .sck(sck0), .mosi(mosi), .load(load), .tx_byte(peer_tx), .miso(miso), .rx_byte(peer_rx));
   // ----------------------------------------
   // bus and compare helpers
   // ----------------------------------------
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d, logic [7:0] m = 8'hff);
      @(negedge clk);
      addr = a;
      wdata = d;
      wmask = m;
      bus_wr = 1'b1;
      @(negedge clk);
      bus_wr = 1'b0;
   endtask
   task automatic rd(logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      bus_rd = 1'b1;
      @(negedge clk);
      bus_rd = 1'b0;
      d = (bus_rvalid === 1'b1) ? rdata : 8'hxx;
   endtask
   task automatic wr_rd(logic [15:0] a, logic [7:0] d, logic [7:0] m, logic [7:0] e);
      wr(a, d, m);
      rd(a, rv);
      check("register", rv, e);
   endtask
   // bounded poll of the busy flag
   task automatic wait_idle();
      for (int i = 0; i < 2000; i++) begin
         rd(16'hff80, rv);
         if (rv[0] === 1'b0) break;
      end
      check("busy clear", {7'h00, rv[0]}, 8'h00);
   endtask
   function automatic logic [7:0] rev(logic [7:0] b);
      return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
   endfunction
   // one byte through channel zero against the peer
   task automatic xfer(logic [7:0] mode, logic [7:0] tx, logic [7:0] peer,
                       logic [7:0] exp_rx, logic [7:0] exp_peer);
      // byte settles a cycle before the load edge picks it up
      peer_tx = peer;
      @(negedge clk);
      load = 1'b1;
      @(negedge clk);
      load = 1'b0;
      wr(16'hff80, mode);
      if (mode[6]) begin
         wr(16'hff82, tx);
      end else begin
         rd(16'hff83, rv);
      end
      rd(16'hff80, rv);
      check("busy set", {7'h00, rv[0]}, 8'h01);
      wait_idle();
      rd(16'hff83, rv);
      check("shift in", rv, exp_rx);
      check("peer rx", peer_rx, exp_peer);
      wr(16'hff80, 8'h00);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [15:0] al[7] = '{16'hff80, 16'hff81, 16'hff83, 16'hff88, 16'hff89, 16'hff8b, 16'hff90};
      foreach (al[i]) begin
         rd(al[i], rv);
         check("reset value", rv, 8'h00);
      end
      wr_rd(16'hff89, 8'hff, 8'hff, 8'h1f);
      wr_rd(16'hff89, 8'h00, 8'hff, 8'h00);
      wr_rd(16'hff88, 8'hff, 8'hff, 8'hf0);
      check("ch1 clock drive", {7'h00, sck_oe_n[1]}, 8'h00);
      check("ch1 out drive", {7'h00, so_oe_n[1]}, 8'h00);
      // deselected channel one lets go of its data line
      ss_n = 1'b1;
      @(negedge clk);
      check("ch1 out release", {7'h00, so_oe_n[1]}, 8'h01);
      ss_n = 1'b0;
      wr_rd(16'hff88, 8'h00, 8'h80, 8'h70);
      wr_rd(16'hff88, 8'h00, 8'hff, 8'h00);
      wr_rd(16'hff80, 8'h01, 8'hff, 8'h00);
      wr_rd(16'hff81, 8'h07, 8'hff, 8'h07);
      wr_rd(16'hff81, 8'h00, 8'h07, 8'h00);
      wr_rd(16'hff90, 8'hff, 8'hff, 8'h00);
      $display("done: registers");
   endtask
   task automatic t_msb();
      xfer(8'hc0, 8'ha5, 8'h3c, 8'h3c, 8'ha5);
      $display("done: msb first");
   endtask
   task automatic t_lsb();
      xfer(8'hd0, 8'h1e, 8'h2c, rev(8'h2c), rev(8'h1e));
      $display("done: lsb first");
   endtask
   task automatic t_rx_only();
      xfer(8'h80, 8'h00, 8'h96, 8'h96, 8'h00);
      $display("done: receive only");
   endtask
   // half period must be 2^code system clocks
   task automatic t_div();
      int  n;
      logic p;
      wr(16'hff81, 8'h02);
      wr(16'hff80, 8'hc0);
      wr(16'hff82, 8'h55);
      for (int k = 0; k < 2; k++) begin
         p = sck_out[0];
         n = 0;
         while (sck_out[0] === p && n < 40) begin
            @(negedge clk);
            n++;
         end
      end
      check("half period", 8'(n), 8'h04);
      wait_idle();
      wr(16'hff80, 8'h00);
      wr(16'hff81, 8'h00);
      $display("done: divider");
   endtask
   // disable mid-frame clears busy and shift register
   task automatic t_abort();
      wr(16'hff81, 8'h06);
      wr(16'hff80, 8'hc0);
      wr(16'hff82, 8'hff);
      repeat (100) @(negedge clk);
      // single bit write drops enable only, mode bit stays as it was
      wr(16'hff80, 8'h00, 8'h80);
      rd(16'hff80, rv);
      check("abort busy", rv, 8'h40);
      rd(16'hff83, rv);
      check("abort shift", rv, 8'h00);
      wr(16'hff80, 8'h00);
      wr(16'hff81, 8'h00);
      $display("done: abort");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard, far beyond the expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      {rst_n, bus_wr, bus_rd, load} = 4'h0;
      ss_n = 1'b0;
      {addr, wdata, wmask, peer_tx} = 40'h0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_regs();
      t_msb();
      t_lsb();
      t_rx_only();
      t_div();
      t_abort();
      print_verdict();
   end
endmodule
